// >>> design/tkc_pkg.sv
// Shared constants for the touch-key counter block.
package tkc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry.
  localparam int unsigned ADDR_W = 8; // Byte address width.
  localparam int unsigned DATA_W = 32; // APB data width.

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses, one aligned word each.
  localparam logic [7:0] ADDR_PRESET = 8'h00; // Slot timer preset.
  localparam logic [7:0] ADDR_CTRL = 8'h04; // Control and status.
  localparam logic [7:0] ADDR_OSCSEL = 8'h08; // Oscillator frequency.
  localparam logic [7:0] ADDR_REFL = 8'h0C; // Reference count low.
  localparam logic [7:0] ADDR_REFH = 8'h10; // Reference count high.
  localparam logic [7:0] ADDR_PINSEL = 8'h14; // Pin function select.
  localparam logic [7:0] ADDR_SRC = 8'h18; // Key and slot clock source.
  localparam logic [7:0] ADDR_ISTAT = 8'h1C; // Interrupt status.
  localparam logic [7:0] ADDR_IMASK = 8'h20; // Interrupt mask.

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int unsigned CTRL_SLOT_OVF = 6; // Slot overflow flag.
  localparam int unsigned CTRL_START = 5; // Start detection.
  localparam int unsigned CTRL_CF_OVF = 4; // C/F counter overflow flag.
  localparam int unsigned CTRL_REF_OVF = 3; // Reference counter overflow.
  localparam int unsigned CTRL_SLOT_SOURCE_SELECT = 2; // Slot source select.
  localparam int unsigned CTRL_CLK = 0; // Counter clock select, 2 bits.
  localparam int unsigned SRC_KEY0 = 0; // Module zero key select, 2 bits.
  localparam int unsigned SRC_KEY1 = 2; // Module one key select.
  localparam int unsigned SRC_CLK0 = 4; // Module zero slot clock source.
  localparam int unsigned SRC_CLK1 = 5; // Module one slot clock source.
  localparam int unsigned IST_SLOT = 0; // Touch interrupt request.
  localparam int unsigned IST_CF = 1; // C/F overflow event.
  localparam int unsigned IST_REF = 2; // Reference overflow event.
  localparam int unsigned IRQ_W = 3; // Interrupt status width.

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset and counter limits.
  localparam logic [7:0] PRESET_RST = 8'h00;
  localparam logic [1:0] OSCSEL_RST = 2'h3;
  localparam logic [5:0] PINSEL_RST = 6'h00;
  localparam logic [5:0] SRC_RST = 6'h00;
  localparam logic [2:0] IMASK_RST = 3'h0;
  localparam logic [4:0] PRESC_LAST = 5'h1F; // Divide by 32.
  localparam logic [7:0] SLOT_LAST = 8'hFF; // Last slot count.
  localparam logic [15:0] CNT_LAST = 16'hFFFF; // Last 16-bit count.
  localparam int unsigned NKEY0 = 4; // Keys of module zero.
  localparam int unsigned NKEY1 = 2; // Keys of module one.
  localparam int unsigned NOSC = NKEY0 + NKEY1 + 2; // Synchronised inputs.

  // Counter clock division codes.
  typedef enum logic [1:0] {TKC_DIV1, TKC_DIV2, TKC_DIV4, TKC_DIV8} tkc_div_e;

  // One-cycle tick of the system clock divided as the code asks.
  function automatic logic tkc_div_tick(input tkc_div_e sel,
                                        input logic [2:0] cnt);
    case (sel)
      TKC_DIV1: tkc_div_tick = 1'b1;
      TKC_DIV2: tkc_div_tick = (cnt[0] == 1'b0);
      TKC_DIV4: tkc_div_tick = (cnt[1:0] == 2'h0);
      TKC_DIV8: tkc_div_tick = (cnt == 3'h0);
      default: tkc_div_tick = 1'b1;
    endcase
  endfunction : tkc_div_tick

endpackage : tkc_pkg

// >>> design/tkc_unit.sv
`timescale 1ns/100ps
// One touch-key module: C/F counter, reference counter and slot timer.
module tkc_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic clear_cnt,
  input wire logic clear_all,
  input wire logic load,
  input wire logic [7:0] preset,
  input wire logic sense_tick,
  input wire logic ref_tick,
  input wire logic slot_tick,
  output logic slot_ovf,
  output logic cf_ovf,
  output logic ref_ovf,
  output logic [15:0] ref_count
);
  import tkc_pkg::*;

  logic [15:0] cf_ff; // Sense oscillator cycles.
  logic [15:0] ref_ff; // Divided system clock cycles.
  logic [4:0] presc_ff; // Divide-by-32 slot prescaler.
  logic [7:0] slot_ff; // Programmable slot counter.
  logic wrap; // Prescaler wraps this cycle.

  assign wrap = run & slot_tick & (presc_ff == PRESC_LAST);
  assign slot_ovf = wrap & (slot_ff == SLOT_LAST);
  assign cf_ovf = run & sense_tick & (cf_ff == CNT_LAST);
  assign ref_ovf = run & ref_tick & (ref_ff == CNT_LAST);
  assign ref_count = ref_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Counters clear first; the slot counter survives a plain stop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cf_ff <= 16'h0000;
      ref_ff <= 16'h0000;
      presc_ff <= 5'h00;
    end else if (clear_cnt) begin
      cf_ff <= 16'h0000;
      ref_ff <= 16'h0000;
      presc_ff <= 5'h00;
    end else if (run) begin
      cf_ff <= cf_ff + {15'h0000, sense_tick};
      ref_ff <= ref_ff + {15'h0000, ref_tick};
      presc_ff <= presc_ff + {4'h0, slot_tick};
    end
  end

  // The slot counter is preloaded at start and advances on each wrap.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_ff <= 8'h00;
    end else if (clear_all) begin
      slot_ff <= 8'h00;
    end else if (load) begin
      slot_ff <= preset;
    end else if (wrap) begin
      slot_ff <= slot_ff + 8'h01;
    end
  end

  a_slot_advance: assert property (
    @(posedge pclk) disable iff (!presetn)
    wrap && !clear_all && !load |=> slot_ff == $past(slot_ff) + 8'h01)
    else $error("slot counter did not advance on prescaler wrap");

endmodule : tkc_unit

// >>> design/tkc_top.sv
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module tkc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tkc_pkg::ADDR_W-1:0] paddr,
  input wire logic [tkc_pkg::DATA_W-1:0] pwdata,
  output logic [tkc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [tkc_pkg::NKEY0+tkc_pkg::NKEY1-1:0] key_osc_in,
  input wire logic [1:0] ref_osc_in,
  output logic [tkc_pkg::NKEY0+tkc_pkg::NKEY1-1:0] key_pin_touch,
  output logic [tkc_pkg::NKEY0+tkc_pkg::NKEY1-1:0] key_osc_en,
  output logic [1:0] ref_osc_en,
  output logic [1:0] osc_freq_code,
  output logic irq
);
  import tkc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [7:0] preset_ff; // Slot timer preset.
  logic slot_flag_ff; // Slot overflow flag.
  logic start_ff; // Start detection bit.
  logic start_d_ff; // Start bit one cycle ago.
  logic cf_flag_ff; // C/F overflow flag.
  logic ref_flag_ff; // Reference overflow flag.
  logic slot_source_select_ff; // Shared slot timing select.
  tkc_div_e clk_sel_ff; // Counter clock division.
  logic [1:0] osc_code_ff; // Oscillator frequency code.
  logic [5:0] pin_sel_ff; // One per pin: touch when set.
  logic [5:0] src_ff; // Key and slot clock source bits.
  logic [IRQ_W-1:0] istat_ff; // Sticky event bits.
  logic [IRQ_W-1:0] imask_ff; // Interrupt enables.
  logic running_ff; // A measurement window is open.
  logic [1:0] done_ff; // Module window has ended.
  logic [2:0] div_ff; // Free system clock divider.
  logic [31:0] prdata_ff; // Read data held for the access phase.
  logic [5:0] key_en_ff; // Key oscillator enables.
  logic [1:0] ref_en_ff; // Reference oscillator enables.
  logic [NOSC-1:0] osc_raw; // All oscillator inputs.
  logic [NOSC-1:0] sy1_ff; // First synchroniser stage.
  logic [NOSC-1:0] sy2_ff; // Second synchroniser stage.
  logic [NOSC-1:0] sy3_ff; // Third synchroniser stage.
  logic [NOSC-1:0] lvl_ff; // Accepted level.
  logic [NOSC-1:0] rise; // Accepted rising edge.
  logic setup_ph; // APB setup cycle.
  logic access_ph; // APB access cycle.
  logic wr_ctrl; // Write to the control register.
  logic wr_istat; // Write to the interrupt status.
  logic start_rise; // Start bit went from low to high.
  logic ovf_evt; // Window ends: module zero overflowed, or both with own timing.
  logic cf_evt; // Any C/F counter overflowed.
  logic ref_evt; // Any reference counter overflowed.
  logic clear_cnt; // Clears C/F, reference and prescaler.
  logic ctr_tick; // 16-bit counter clock.
  logic f4_tick; // System clock over four.
  logic [1:0] slot_tick; // Slot clock per module.
  logic [1:0] sense_tick; // Selected key edge per module.
  logic [1:0] run_m; // Per-module counting enable.
  logic [1:0] m_ovf; // Per-module slot overflow.
  logic [1:0] m_cf; // Per-module C/F overflow.
  logic [1:0] m_ref; // Per-module reference overflow.
  logic [15:0] ref0; // Module zero reference count.
  logic [15:0] ref1; // Module one reference count.
  logic [7:0] ctrl_rd; // Control register as read.

  // Decode of the mapped addresses that the error answer uses.
  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      ADDR_PRESET, ADDR_CTRL, ADDR_OSCSEL, ADDR_REFL, ADDR_REFH,
      ADDR_PINSEL, ADDR_SRC, ADDR_ISTAT, ADDR_IMASK: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction : addr_mapped

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, error on an unmapped address.
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_ctrl = access_ph & pwrite & (paddr == ADDR_CTRL);
  assign wr_istat = access_ph & pwrite & (paddr == ADDR_ISTAT);
  assign pready = 1'b1;
  assign pslverr = access_ph & ~addr_mapped(paddr);
  assign prdata = prdata_ff;

  assign ctrl_rd = {1'b0, slot_flag_ff, start_ff, cf_flag_ff, ref_flag_ff,
                    slot_source_select_ff, clk_sel_ff};

  // Read data is fetched in the setup cycle so that the access phase can
  // finish at once; a register that changes in between shows its older value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      case (paddr)
        ADDR_PRESET: prdata_ff <= {24'h000000, preset_ff};
        ADDR_CTRL: prdata_ff <= {24'h000000, ctrl_rd};
        ADDR_OSCSEL: prdata_ff <= {30'h00000000, osc_code_ff};
        ADDR_REFL: prdata_ff <= {24'h000000, ref0[7:0]};
        ADDR_REFH: prdata_ff <= {24'h000000, ref0[15:8]};
        ADDR_PINSEL: prdata_ff <= {26'h0000000, pin_sel_ff};
        ADDR_SRC: prdata_ff <= {26'h0000000, src_ff};
        ADDR_ISTAT: prdata_ff <= {29'h00000000, istat_ff};
        ADDR_IMASK: prdata_ff <= {29'h00000000, imask_ff};
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain configuration registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preset_ff <= PRESET_RST;
      osc_code_ff <= OSCSEL_RST;
      pin_sel_ff <= PINSEL_RST;
      src_ff <= SRC_RST;
      imask_ff <= IMASK_RST;
    end else if (access_ph && pwrite) begin
      case (paddr)
        ADDR_PRESET: preset_ff <= pwdata[7:0];
        ADDR_OSCSEL: osc_code_ff <= pwdata[1:0];
        ADDR_PINSEL: pin_sel_ff <= pwdata[5:0];
        ADDR_SRC: src_ff <= pwdata[5:0];
        ADDR_IMASK: imask_ff <= pwdata[IRQ_W-1:0];
        default: preset_ff <= preset_ff;
      endcase
    end
  end

  // Start, source select and clock select are software-only fields.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_ff <= 1'b0;
      slot_source_select_ff <= 1'b0;
      clk_sel_ff <= TKC_DIV1;
      start_d_ff <= 1'b0;
    end else begin
      start_d_ff <= start_ff;
      if (wr_ctrl) begin
        start_ff <= pwdata[CTRL_START];
        slot_source_select_ff <= pwdata[CTRL_SLOT_SOURCE_SELECT];
        clk_sel_ff <= tkc_div_e'(pwdata[CTRL_CLK+:2]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags. Hardware setting wins over a software write of zero.
  // Writing one to the slot flag sets only the flag, never the request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_flag_ff <= 1'b0;
    end else if (ovf_evt) begin
      slot_flag_ff <= 1'b1;
    end else if (wr_ctrl) begin
      slot_flag_ff <= pwdata[CTRL_SLOT_OVF];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cf_flag_ff <= 1'b0;
    end else if (cf_evt) begin
      cf_flag_ff <= 1'b1;
    end else if (wr_ctrl) begin
      cf_flag_ff <= pwdata[CTRL_CF_OVF];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_flag_ff <= 1'b0;
    end else if (ref_evt) begin
      ref_flag_ff <= 1'b1;
    end else if (wr_ctrl) begin
      ref_flag_ff <= pwdata[CTRL_REF_OVF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: write one to clear, a new event wins the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_ff <= 3'h0;
    end else begin
      istat_ff <= (istat_ff & ~(wr_istat ? pwdata[IRQ_W-1:0] : 3'h0)) |
                  {ref_evt, cf_evt, ovf_evt};
    end
  end

  assign irq = |(istat_ff & imask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator inputs come from analog cells outside the clock domain.
  // An edge is accepted only once stages two and three agree.
  assign osc_raw = {ref_osc_in, key_osc_in};

  genvar g;
  generate
    for (g = 0; g < NOSC; g++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sy1_ff[g] <= 1'b0;
          sy2_ff[g] <= 1'b0;
          sy3_ff[g] <= 1'b0;
          lvl_ff[g] <= 1'b0;
        end else begin
          sy1_ff[g] <= osc_raw[g];
          sy2_ff[g] <= sy1_ff[g];
          sy3_ff[g] <= sy2_ff[g];
          if (sy2_ff[g] == sy3_ff[g]) begin
            lvl_ff[g] <= sy3_ff[g];
          end
        end
      end
      assign rise[g] = (sy2_ff[g] == sy3_ff[g]) & sy3_ff[g] & ~lvl_ff[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Free divider for the counter clock and the system clock over four.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 3'h0;
    end else begin
      div_ff <= div_ff + 3'h1;
    end
  end

  assign ctr_tick = tkc_div_tick(clk_sel_ff, div_ff);
  assign f4_tick = tkc_div_tick(TKC_DIV4, div_ff);

  // Each module counts the edges of one key chosen by software.
  assign sense_tick[0] = rise[src_ff[SRC_KEY0+:2]];
  assign sense_tick[1] = rise[NKEY0 + {2'h0, src_ff[SRC_KEY1]}];
  assign slot_tick[0] = src_ff[SRC_CLK0] ? f4_tick : rise[NOSC-2];
  assign slot_tick[1] = src_ff[SRC_CLK1] ? f4_tick : rise[NOSC-1];

  ////////////////////////////////////////////////////////////////////////////
  // Window control. With shared timing, module one ignores its own slot
  // counter and closes together with module zero.
  assign start_rise = start_ff & ~start_d_ff;
  assign cf_evt = |m_cf;
  assign ref_evt = |m_ref;
  assign ovf_evt = running_ff & (slot_source_select_ff ? m_ovf[0] :
                   ((m_ovf[0] | done_ff[0]) & (m_ovf[1] | done_ff[1])));
  assign clear_cnt = ~start_ff | ovf_evt;
  assign run_m = {2{running_ff}} & ~done_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running_ff <= 1'b0;
    end else if (ovf_evt) begin
      running_ff <= 1'b0;
    end else if (start_rise) begin
      running_ff <= 1'b1;
    end
  end

  // A module whose own window ended stops counting until the next start.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_ff <= 2'h0;
    end else if (start_rise || ovf_evt) begin
      done_ff <= 2'h0;
    end else begin
      done_ff <= done_ff | (m_ovf & {~slot_source_select_ff, 1'b1});
    end
  end

  // Oscillators run only inside a window; key oscillators only on touch-mode pins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_en_ff <= 6'h00;
      ref_en_ff <= 2'h0;
    end else begin
      key_en_ff <= {{2{run_m[1]}}, {4{run_m[0]}}} & pin_sel_ff;
      ref_en_ff <= run_m;
    end
  end

  assign key_osc_en = key_en_ff;
  assign ref_osc_en = ref_en_ff;
  assign key_pin_touch = pin_sel_ff;
  assign osc_freq_code = osc_code_ff;

  ////////////////////////////////////////////////////////////////////////////
  // The two modules.
  tkc_unit u_module_zero (
    .pclk(pclk), .presetn(presetn), .run(run_m[0]),
    .clear_cnt(clear_cnt), .clear_all(ovf_evt), .load(start_rise),
    .preset(preset_ff), .sense_tick(sense_tick[0]), .ref_tick(ctr_tick),
    .slot_tick(slot_tick[0]), .slot_ovf(m_ovf[0]), .cf_ovf(m_cf[0]),
    .ref_ovf(m_ref[0]), .ref_count(ref0)
  );

  tkc_unit u_module_one (
    .pclk(pclk), .presetn(presetn), .run(run_m[1]),
    .clear_cnt(clear_cnt), .clear_all(ovf_evt), .load(start_rise),
    .preset(preset_ff), .sense_tick(sense_tick[1]), .ref_tick(ctr_tick),
    .slot_tick(slot_tick[1]), .slot_ovf(m_ovf[1]), .cf_ovf(m_cf[1]),
    .ref_ovf(m_ref[1]), .ref_count(ref1)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_stop_then_quiet;
    !running_ff ##1 (key_osc_en == 6'h00 && ref_osc_en == 2'h0);
  endsequence

  a_start_opens: assert property (start_rise && !ovf_evt |=> running_ff)
    else $error("start edge did not open a window");

  a_ovf_flags: assert property (ovf_evt |=>
    slot_flag_ff && istat_ff[IST_SLOT])
    else $error("overflow did not set flag and request");

  a_ovf_halts: assert property (ovf_evt |=> s_stop_then_quiet)
    else $error("oscillators still enabled after overflow");

  a_sw_set_quiet: assert property (wr_ctrl && pwdata[CTRL_SLOT_OVF] &&
    !ovf_evt && !istat_ff[IST_SLOT] |=> slot_flag_ff && !istat_ff[IST_SLOT])
    else $error("software flag set raised a request");

  a_flag_sticky: assert property (slot_flag_ff &&
    !(wr_ctrl && !pwdata[CTRL_SLOT_OVF]) |=> slot_flag_ff)
    else $error("slot flag dropped without a clearing write");

  a_cf_flag: assert property (cf_evt |=> cf_flag_ff && istat_ff[IST_CF])
    else $error("C/F overflow flag not set");

  a_ref_flag: assert property (ref_evt |=> ref_flag_ff)
    else $error("reference overflow flag not set");

  a_stop_clears: assert property (!start_ff |=> ref0 == 16'h0000)
    else $error("reference counter not cleared while stopped");

  a_shared_slot: assert property (running_ff && slot_source_select_ff && m_ovf[0] |=>
    !running_ff)
    else $error("shared timing did not close the window");

endmodule : tkc_top

// >>> verif/capacitive_touch_key_counter_test.sv
`timescale 1ns/100ps
module capacitive_touch_key_counter_test;
  import tkc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] key_osc_in, key_pin_touch, key_osc_en;
  logic [1:0] ref_osc_in, ref_osc_en, osc_freq_code;
  logic [7:0] osc_cnt = 8'h00; // Free-running source for the oscillator pins.
  int bad_count, checks_done;

  tkc_top tkc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_osc_in(key_osc_in), .ref_osc_in(ref_osc_in),
    .key_pin_touch(key_pin_touch), .key_osc_en(key_osc_en),
    .ref_osc_en(ref_osc_en), .osc_freq_code(osc_freq_code), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, and oscillator pins from one counter: keys at clk/4, references at clk/4 and clk/8.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    osc_cnt <= osc_cnt + 8'h01;
    key_osc_in <= {6{osc_cnt[1]}} ^ 6'h2A;
    ref_osc_in <= osc_cnt[2:1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // One comparison; any four-state mismatch counts.
  task automatic chk(input logic [31:0] got, exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // Ends the run; the only place that prints the verdict.
  task automatic conclude();
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  // APB transfer: setup, then access held until pready is seen high.
  // The half cycle at the end lets registers written at the completing
  // edge settle before a caller looks at the pins they drive.
  task automatic apb(input logic is_wr, input logic [7:0] a,
                     input logic [31:0] d, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk(1'b0, 1'b1, "pready timeout");
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, e);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
                      input string msg);
    logic e;
    apb(1'b0, a, 32'h0, e);
    chk(rd, exp, msg);
  endtask : rchk

  // Polls the control register until the slot flag is up, within a bound.
  task automatic wait_flag(input int lim);
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_CTRL, 32'h0, e);
      n++;
    end while (rd[CTRL_SLOT_OVF] !== 1'b1 && n < lim);
    if (rd[CTRL_SLOT_OVF] !== 1'b1) begin
      chk(1'b0, 1'b1, "slot flag timeout");
      conclude();
    end
  endtask : wait_flag

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset();
    rchk(ADDR_PRESET, 32'h00, "preset reset");
    rchk(ADDR_CTRL, 32'h00, "ctrl reset");
    rchk(ADDR_OSCSEL, 32'h03, "osc reset");
    rchk(ADDR_REFL, 32'h00, "ref low reset");
    chk(irq, 1'b0, "irq after reset");
  endtask : t_reset

  // Register access, refused address and read-only count.
  task automatic t_regs();
    logic e;
    wr(ADDR_PRESET, 32'hFFFF_FFA5);
    rchk(ADDR_PRESET, 32'hA5, "preset rw");
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_OSCSEL, c);
      chk(osc_freq_code, c[1:0], "osc code pin");
    end
    wr(ADDR_REFL, 32'h5A);
    rchk(ADDR_REFL, 32'h00, "ref low read only");
    apb(1'b1, 8'h3C, 32'h1, e);
    chk(e, 1'b1, "unmapped error");
    wr(ADDR_PINSEL, 32'h3F);
    chk(key_pin_touch, 6'h3F, "touch pins");
  endtask : t_regs

  // Counter clock divider; stop clears the count.
  task automatic t_div();
    logic e;
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CTRL, 32'h20 | c);
      repeat (64) @(posedge pclk);
      apb(1'b0, ADDR_REFL, 32'h0, e);
      checks_done++;
      if ((rd >= (60 >> c) && rd <= (76 >> c) + 1) !== 1'b1) begin
        bad_count++;
        $display("MISMATCH %0t count %0d for div code %0d", $time, rd, c);
      end
      wr(ADDR_CTRL, c);
      rchk(ADDR_REFL, 32'h0, "count after stop");
    end
  endtask : t_div

  // Shared window of (256-254)*32 ticks at clk/4, overflow and interrupt.
  task automatic t_window();
    wr(ADDR_PRESET, 32'hFE);
    wr(ADDR_SRC, 32'h30);
    wr(ADDR_IMASK, 32'h1);
    wr(ADDR_CTRL, 32'h24);
    repeat (8) @(posedge pclk);
    chk(ref_osc_en, 2'h3, "ref osc on");
    repeat (180) @(posedge pclk);
    rchk(ADDR_CTRL, 32'h24, "no early overflow");
    wait_flag(40);
    chk(rd[7:0], 8'h64, "slot flag set");
    repeat (3) @(posedge pclk);
    chk({irq, key_osc_en, ref_osc_en}, 9'h100, "irq, osc halted");
    rchk(ADDR_ISTAT, 32'h1, "request flag");
    rchk(ADDR_REFL, 32'h0, "auto clear");
    wr(ADDR_IMASK, 32'h0);
    chk(irq, 1'b0, "masked irq");
    wr(ADDR_ISTAT, 32'h1);
    rchk(ADDR_ISTAT, 32'h0, "status cleared");
    wr(ADDR_CTRL, 32'h0);
    rchk(ADDR_CTRL, 32'h0, "flag cleared by zero");
  endtask : t_window

  // Software set of the slot flag leaves the request clear.
  task automatic t_swset();
    wr(ADDR_CTRL, 32'h40);
    rchk(ADDR_CTRL, 32'h40, "flag set by write");
    rchk(ADDR_ISTAT, 32'h0, "no request");
    wr(ADDR_CTRL, 32'h0);
    rchk(ADDR_CTRL, 32'h0, "flag clear");
  endtask : t_swset

  // Own slot timing: module zero on clk/4 ends first and stops alone,
  // module one on its slower reference decides when the window closes.
  task automatic t_own_slot();
    wr(ADDR_SRC, 32'h10);
    wr(ADDR_CTRL, 32'h20);
    repeat (300) @(posedge pclk);
    chk(ref_osc_en, 2'h2, "module zero stopped alone");
    rchk(ADDR_CTRL, 32'h20, "window still open");
    wait_flag(100);
    chk(rd[7:0], 8'h60, "own slot overflow");
    rchk(ADDR_ISTAT, 32'h1, "request after own slot");
    wr(ADDR_ISTAT, 32'h1);
    wr(ADDR_CTRL, 32'h0);
  endtask : t_own_slot

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset held five cycles, then every scenario.
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0;
    bad_count = 0; checks_done = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_div();
    t_swset();
    t_window();
    t_own_slot();
    conclude();
  end
endmodule : capacitive_touch_key_counter_test
